// ===== rtl/pmt_pkg.sv
// constants and helpers shared by the pm timer and throttle block
package pmt_pkg;

  // register offsets
  localparam logic [7:0] EVT_CTL_OFS = 8'h00;
  localparam logic [7:0] TMR_OFS = 8'h08;
  localparam logic [7:0] THR_OFS = 8'h10;

  // field positions
  localparam int OVF_FLAG_BIT = 0;
  localparam int OVF_EN_BIT = 8;
  localparam int SCI_SEL_BIT = 9;
  localparam int THR_STS_BIT = 17;
  localparam int DUTY_LSB = 5;
  localparam int DUTY_MSB = 7;
  localparam int CNT_MSB = 23;
  localparam int OVF_BIT = 22;

  // reset values
  localparam logic [23:0] CNT_RST = 24'h000000;
  localparam logic [2:0] DUTY_RST = 3'h0;
  localparam logic [31:0] RDATA_RST = 32'h00000000;

  // timing
  localparam logic [1:0] REF_DIV_LAST = 2'h3;
  localparam logic [9:0] PERIOD_LAST = 10'h3FF;
  localparam int OVF_PERIOD_US = 2343500;

  // stop-clock low clocks within each 1024-clock period
  function automatic logic [9:0] duty_clocks(input logic [2:0] code);
    logic [9:0] n;
    n = 10'h200;
    unique case (code)
      3'h1: n = 10'h380;
      3'h2: n = 10'h300;
      3'h3: n = 10'h280;
      3'h4: n = 10'h200;
      3'h5: n = 10'h180;
      3'h6: n = 10'h100;
      3'h7: n = 10'h080;
      3'h0: n = 10'h200;
    endcase
    return n;
  endfunction

endpackage

// ===== rtl/pmt_tick_gen.sv
// divides the 14.31818 MHz reference pulse train by four
`timescale 1ns/1ps
module pmt_tick_gen (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // reference pulse, one cycle per reference clock
  input wire logic ref_tick,
  // timer tick at a quarter of the reference rate
  output logic timer_tick
);

  logic [1:0] div_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= 2'h0;
    end else if (ref_tick) begin
      div_reg <= div_reg + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_tick <= 1'b0;
    end else begin
      timer_tick <= ref_tick && (div_reg == pmt_pkg::REF_DIV_LAST);
    end
  end

endmodule

// ===== rtl/pmt_duty_gen.sv
// stop-clock duty pattern over a 1024 pci clock period
`timescale 1ns/1ps
module pmt_duty_gen (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic pci_tick,
  input wire logic throttle_on,
  input wire logic [2:0] duty_code,
  // stop-clock, low active
  output logic stop_clock_n
);

  logic [9:0] phase_reg;
  logic [9:0] low_len;

  assign low_len = pmt_pkg::duty_clocks(duty_code);

  // restart at phase zero each time throttling begins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_reg <= 10'h000;
    end else if (!throttle_on) begin
      phase_reg <= 10'h000;
    end else if (pci_tick) begin
      phase_reg <= phase_reg + 10'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stop_clock_n <= 1'b1;
    end else begin
      stop_clock_n <= !(throttle_on && (phase_reg < low_len));
    end
  end

  chk_period_wrap: assert property (@(posedge clk) disable iff (!rst_b)
    throttle_on && pci_tick && phase_reg == pmt_pkg::PERIOD_LAST |=> phase_reg == 10'h000)
    else $error("throttle period did not wrap at 1024");

  chk_low_length: assert property (@(posedge clk) disable iff (!rst_b)
    throttle_on && phase_reg >= low_len |=> stop_clock_n)
    else $error("stop-clock low beyond selected length");

endmodule

// ===== rtl/pmt_top.sv
// pm timer with overflow event and thermal throttle control
`timescale 1ns/1ps
module pmt_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,

  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,

  // system reset and clock pulses
  input wire logic pci_bus_reset_n,
  input wire logic ref_tick,
  input wire logic pci_tick,

  // system and processor state
  input wire logic sys_in_s0,
  input wire logic cpu_in_c0,
  input wire logic cpu_in_c2,
  input wire logic thermal_override,
  input wire logic hw_throttle_active,

  // outputs to processor and interrupt logic
  output logic stop_clock_n,
  output logic sci_out,
  output logic system_management_interrupt_n
);

  logic timer_tick;
  logic [23:0] timer_count_value;
  logic [23:0] count_next;
  logic ovf_event;
  logic timer_overflow_flag;
  logic timer_overflow_enable;
  logic sci_select;
  logic [2:0] thermal_duty_code;
  logic duty_locked_reg;
  logic throttle_active_status;
  logic thermal_on;
  logic count_run;
  logic wr_evt;
  logic wr_thr;
  logic ovf_clear;
  logic [31:0] rd_mux;

  // tick source
  pmt_tick_gen u_tick (
    .clk(clk),
    .rst_b(rst_b),
    .ref_tick(ref_tick),
    .timer_tick(timer_tick)
  );

  // address decode
  assign wr_evt = reg_wr && (reg_addr == pmt_pkg::EVT_CTL_OFS);
  assign wr_thr = reg_wr && (reg_addr == pmt_pkg::THR_OFS);

  // running count

  assign count_run = timer_tick && sys_in_s0 && pci_bus_reset_n;
  assign count_next = timer_count_value + 24'h000001;

  // the timer offset has no write path, so writes cannot disturb the count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_count_value <= pmt_pkg::CNT_RST;
    end else if (!pci_bus_reset_n) begin
      timer_count_value <= pmt_pkg::CNT_RST;
    end else if (count_run) begin
      timer_count_value <= count_next;
    end
  end

  // overflow event

  // bit 22 falls once per 2^23 ticks, about 2.3435 s at the tick rate
  assign ovf_event = count_run
    && timer_count_value[pmt_pkg::OVF_BIT]
    && !count_next[pmt_pkg::OVF_BIT];

  assign ovf_clear = wr_evt && reg_wdata[pmt_pkg::OVF_FLAG_BIT];

  // a new event in the clearing cycle keeps the flag set
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_overflow_flag <= 1'b0;
    end else if (!pci_bus_reset_n) begin
      timer_overflow_flag <= 1'b0;
    end else begin
      timer_overflow_flag <= ovf_event || (timer_overflow_flag && !ovf_clear);
    end
  end

  // event enables
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_overflow_enable <= 1'b0;
      sci_select <= 1'b0;
    end else if (!pci_bus_reset_n) begin
      timer_overflow_enable <= 1'b0;
      sci_select <= 1'b0;
    end else if (wr_evt) begin
      timer_overflow_enable <= reg_wdata[pmt_pkg::OVF_EN_BIT];
      sci_select <= reg_wdata[pmt_pkg::SCI_SEL_BIT];
    end
  end

  // interrupt delivery
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sci_out <= 1'b0;
      system_management_interrupt_n <= 1'b1;
    end else begin
      sci_out <= timer_overflow_flag && timer_overflow_enable && sci_select;
      system_management_interrupt_n <=
        !(timer_overflow_flag && timer_overflow_enable && !sci_select);
    end
  end

  // thermal duty, write-once

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      thermal_duty_code <= pmt_pkg::DUTY_RST;
      duty_locked_reg <= 1'b0;
    end else if (!pci_bus_reset_n) begin
      thermal_duty_code <= pmt_pkg::DUTY_RST;
      duty_locked_reg <= 1'b0;
    end else if (wr_thr && !duty_locked_reg) begin
      thermal_duty_code <= reg_wdata[pmt_pkg::DUTY_MSB:pmt_pkg::DUTY_LSB];
      duty_locked_reg <= 1'b1;
    end
  end

  // thermal throttle
  // no software gate: overheating must never be masked off
  assign thermal_on = thermal_override && cpu_in_c0 && !cpu_in_c2;

  pmt_duty_gen u_duty (
    .clk(clk),
    .rst_b(rst_b),
    .pci_tick(pci_tick),
    .throttle_on(thermal_on),
    .duty_code(thermal_duty_code),
    .stop_clock_n(stop_clock_n)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      throttle_active_status <= 1'b0;
    end else begin
      throttle_active_status <= thermal_on || hw_throttle_active;
    end
  end

  // read path

  always_comb begin
    rd_mux = pmt_pkg::RDATA_RST;
    unique case (reg_addr)
      pmt_pkg::TMR_OFS: begin
        rd_mux[pmt_pkg::CNT_MSB:0] = timer_count_value;
      end
      pmt_pkg::THR_OFS: begin
        rd_mux[pmt_pkg::THR_STS_BIT] = throttle_active_status;
        rd_mux[pmt_pkg::DUTY_MSB:pmt_pkg::DUTY_LSB] = thermal_duty_code;
      end
      pmt_pkg::EVT_CTL_OFS: begin
        rd_mux[pmt_pkg::OVF_FLAG_BIT] = timer_overflow_flag;
        rd_mux[pmt_pkg::OVF_EN_BIT] = timer_overflow_enable;
        rd_mux[pmt_pkg::SCI_SEL_BIT] = sci_select;
      end
      default: begin
        rd_mux = pmt_pkg::RDATA_RST;
      end
    endcase
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= pmt_pkg::RDATA_RST;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= pmt_pkg::RDATA_RST;
    end
  end

  // checks

  chk_count_clear: assert property (@(posedge clk) disable iff (!rst_b)
    !pci_bus_reset_n |=> timer_count_value == 24'h000000)
    else $error("count not cleared under pci reset");

  chk_count_step: assert property (@(posedge clk) disable iff (!rst_b)
    timer_tick && sys_in_s0 && pci_bus_reset_n
    |=> timer_count_value == $past(timer_count_value) + 24'h000001)
    else $error("count did not step on tick");

  chk_count_hold: assert property (@(posedge clk) disable iff (!rst_b)
    pci_bus_reset_n && !(timer_tick && sys_in_s0) |=> $stable(timer_count_value))
    else $error("count moved without tick in S0");

  chk_write_ignore: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == pmt_pkg::TMR_OFS && !timer_tick && pci_bus_reset_n
    |=> $stable(timer_count_value) && $stable(timer_overflow_flag))
    else $error("timer write changed state");

  chk_ovf_set: assert property (@(posedge clk) disable iff (!rst_b)
    count_run && timer_count_value[22:0] == 23'h7FFFFF
    |=> timer_overflow_flag)
    else $error("bit 22 fall did not set flag");

  chk_ovf_sticky: assert property (@(posedge clk) disable iff (!rst_b)
    timer_overflow_flag && pci_bus_reset_n && !ovf_clear |=> timer_overflow_flag)
    else $error("overflow flag dropped without clear");

  chk_sci_raise: assert property (@(posedge clk) disable iff (!rst_b)
    timer_overflow_flag && timer_overflow_enable && sci_select |=> sci_out)
    else $error("sci not raised");

  chk_smi_route: assert property (@(posedge clk) disable iff (!rst_b)
    timer_overflow_flag && timer_overflow_enable && !sci_select
    |=> !system_management_interrupt_n && !sci_out)
    else $error("smi routing wrong");

  chk_duty_lock: assert property (@(posedge clk) disable iff (!rst_b)
    duty_locked_reg && pci_bus_reset_n |=> $stable(thermal_duty_code))
    else $error("locked duty field changed");

  chk_no_throttle: assert property (@(posedge clk) disable iff (!rst_b)
    !(thermal_override && cpu_in_c0 && !cpu_in_c2) |=> stop_clock_n)
    else $error("stop-clock asserted outside C0 override");

  chk_status_bit: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd && reg_addr == pmt_pkg::THR_OFS && throttle_active_status
    |=> reg_rdata[17])
    else $error("throttle status not read back");

  chk_reserved_zero: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd && reg_addr == pmt_pkg::TMR_OFS |=> reg_rdata[31:24] == 8'h00)
    else $error("reserved timer bits not zero");

  chk_count_read: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd && reg_addr == pmt_pkg::TMR_OFS |=> reg_rdata[23:0] == $past(timer_count_value))
    else $error("timer read data wrong");

  chk_rdata_idle: assert property (@(posedge clk) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data outside read cycle");

  chk_tick_rate: assert property (@(posedge clk) disable iff (!rst_b)
    timer_tick |=> !timer_tick [*3])
    else $error("timer tick faster than a quarter of reference");

  chk_ovf_only: assert property (@(posedge clk) disable iff (!rst_b)
    !timer_overflow_flag && !ovf_event |=> !timer_overflow_flag)
    else $error("overflow flag set without bit 22 fall");

  chk_flag_pci_reset: assert property (@(posedge clk) disable iff (!rst_b)
    !pci_bus_reset_n |=> !timer_overflow_flag && !timer_overflow_enable && !sci_select)
    else $error("event state not cleared by pci reset");

  chk_ovf_clear: assert property (@(posedge clk) disable iff (!rst_b)
    pci_bus_reset_n && ovf_clear && !ovf_event |=> !timer_overflow_flag)
    else $error("overflow flag not cleared by write");

  chk_irq_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    !(timer_overflow_flag && timer_overflow_enable) |=> !sci_out && system_management_interrupt_n)
    else $error("interrupt without enabled flag");

  chk_evt_readback: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd && reg_addr == pmt_pkg::EVT_CTL_OFS
    |=> reg_rdata[9] == $past(sci_select) && reg_rdata[8] == $past(timer_overflow_enable))
    else $error("event control read back wrong");

  chk_duty_first: assert property (@(posedge clk) disable iff (!rst_b)
    wr_thr && !duty_locked_reg && pci_bus_reset_n
    |=> duty_locked_reg && thermal_duty_code == $past(reg_wdata[7:5]))
    else $error("first duty write not taken");

  chk_duty_default: assert property (@(posedge clk) disable iff (!rst_b)
    !pci_bus_reset_n |=> thermal_duty_code == 3'h0 && !duty_locked_reg)
    else $error("duty field not reset by pci reset");

  chk_duty_read: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd && reg_addr == pmt_pkg::THR_OFS |=> reg_rdata[7:5] == $past(thermal_duty_code))
    else $error("duty field read back wrong");

  chk_thr_reserved: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd && reg_addr == pmt_pkg::THR_OFS
    |=> reg_rdata[31:18] == 14'h0 && reg_rdata[16:8] == 9'h0 && reg_rdata[4:0] == 5'h0)
    else $error("reserved throttle bits not zero");

  chk_status_set: assert property (@(posedge clk) disable iff (!rst_b)
    (thermal_on || hw_throttle_active) |=> throttle_active_status)
    else $error("throttle status not set");

  chk_status_clear: assert property (@(posedge clk) disable iff (!rst_b)
    !thermal_on && !hw_throttle_active |=> !throttle_active_status)
    else $error("throttle status set while running at full speed");

  chk_throttle_start: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(thermal_on) |=> !stop_clock_n)
    else $error("throttling did not start on override");

  cov_overflow: cover property (@(posedge clk) disable iff (!rst_b)
    ovf_event ##1 timer_overflow_flag);

  cov_duty_lock: cover property (@(posedge clk) disable iff (!rst_b)
    duty_locked_reg && wr_thr);

  cov_throttle: cover property (@(posedge clk) disable iff (!rst_b)
    thermal_on ##1 !stop_clock_n);

  cov_sci: cover property (@(posedge clk) disable iff (!rst_b)
    $rose(sci_out));

  cov_smi: cover property (@(posedge clk) disable iff (!rst_b)
    $fell(system_management_interrupt_n));

endmodule

// ===== verif/pmt_cpu_model.sv
// processor side: measures stop-clock low runs and period between assertions
`timescale 1ns/1ps
module pmt_cpu_model (
  // clock
  input wire logic clk,
  // from the block
  input wire logic stop_clock_n,
  // measurements
  output int last_low,
  output int last_period
);
  int low_run = 0;
  int since_fall = 0;
  logic prev_n = 1'b1;

  always @(posedge clk) begin
    prev_n <= stop_clock_n;
    since_fall <= since_fall + 1;
    if (!stop_clock_n) begin
      low_run <= low_run + 1;
    end
    // a run closes when the processor is let go again
    if (stop_clock_n && !prev_n) begin
      last_low <= low_run;
      low_run <= 0;
    end
    if (!stop_clock_n && prev_n) begin
      last_period <= since_fall;
      since_fall <= 1;
    end
  end
endmodule

// ===== verif/pmt_top_tb_top.sv
// self-checking bench for the pm timer and throttle block
`timescale 1ns/1ps
module pmt_top_tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic pci_bus_reset_n = 1'b1;
  logic ref_tick = 1'b1;
  logic pci_tick = 1'b1;
  logic sys_in_s0 = 1'b1;
  logic cpu_in_c0 = 1'b0;
  logic cpu_in_c2 = 1'b0;
  logic thermal_override = 1'b0;
  logic hw_throttle_active = 1'b0;
  logic stop_clock_n;
  logic sci_out;
  logic system_management_interrupt_n;
  int last_low;
  int last_period;
  int num_errors = 0;
  int check_count = 0;
  int seed = 40;
  logic [31:0] a;
  logic [31:0] b;
  logic seen_low;

  always #4 clk = ~clk;

  pmt_top i_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pci_bus_reset_n(pci_bus_reset_n), .ref_tick(ref_tick),
    .pci_tick(pci_tick), .sys_in_s0(sys_in_s0), .cpu_in_c0(cpu_in_c0), .cpu_in_c2(cpu_in_c2),
    .thermal_override(thermal_override), .hw_throttle_active(hw_throttle_active),
    .stop_clock_n(stop_clock_n), .sci_out(sci_out), .system_management_interrupt_n(system_management_interrupt_n));

  pmt_cpu_model i_cpu (.clk(clk), .stop_clock_n(stop_clock_n), .last_low(last_low), .last_period(last_period));

  // stop-clock low clocks expected for each duty code
  function automatic int exp_low(input logic [2:0] c);
    int t[8] = '{10'h200, 10'h380, 10'h300, 10'h280, 10'h200, 10'h180, 10'h100, 10'h080};
    return t[c];
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (exp !== got) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe, taken at the edge that ends it
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask

  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    print_verdict();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    chk("irq idle", 32'h1, {30'h0, sci_out, system_management_interrupt_n});
    rd(8'h10, a);
    chk("throttle reset", 32'h00000000, a);
    // count advances one per four reference ticks, 400 edges apart
    rd(8'h08, a);
    repeat (397) @(posedge clk);
    rd(8'h08, b);
    chk("count step", a + 32'h64, b);
    chk("count top bits", 32'h0, {b[31:24], 24'h0});
    // outside S0 the count holds, and writes do not touch it
    sys_in_s0 <= 1'b0;
    repeat (10) @(posedge clk);
    rd(8'h08, a);
    wr(8'h08, $random(seed));
    repeat (50) @(posedge clk);
    rd(8'h08, b);
    chk("count frozen", a, b);
    sys_in_s0 <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      @(posedge clk);
      pci_bus_reset_n <= 1'b0;
      @(posedge clk);
      pci_bus_reset_n <= 1'b1;
      rd(8'h08, a);
      chk("count after pci reset", 32'h0, a & 32'hFFFFFFF0);
      wr(8'h10, {24'h0, c[2:0], 5'h0});
      wr(8'h10, $random(seed));
      rd(8'h10, a);
      chk("duty locked", {24'h0, c[2:0], 5'h0}, a);
      cpu_in_c0 <= 1'b1;
      thermal_override <= 1'b1;
      repeat (2100) @(posedge clk);
      rd(8'h10, a);
      chk("throttle status", {14'h0, 1'b1, 9'h0, c[2:0], 5'h0}, a);
      chk("low clocks", exp_low(c[2:0]), last_low);
      chk("period", 32'h400, last_period);
      thermal_override <= 1'b0;
    end
    // event enables read back; the flag never sets here, so no interrupt either way
    a = $random(seed) & 32'h00000300;
    wr(8'h00, a | 32'h00000001);
    rd(8'h00, b);
    chk("event enables", a, b);
    chk("irq quiet", 32'h1, {30'h0, sci_out, system_management_interrupt_n});
    @(posedge clk);
    pci_bus_reset_n <= 1'b0;
    @(posedge clk);
    pci_bus_reset_n <= 1'b1;
    rd(8'h00, b);
    chk("event after pci reset", 32'h0, b);
    hw_throttle_active <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h10, a);
    chk("hw status", 32'h1, {31'h0, a[17]});
    hw_throttle_active <= 1'b0;
    // no throttling in C2, nor outside C0
    for (int k = 0; k < 2; k++) begin
      cpu_in_c2 <= (k == 0);
      cpu_in_c0 <= (k == 0);
      thermal_override <= 1'b1;
      seen_low = 1'b0;
      repeat (60) begin
        @(posedge clk);
        seen_low = seen_low | (stop_clock_n !== 1'b1);
      end
      chk("no throttle", 32'h0, {31'h0, seen_low});
      thermal_override <= 1'b0;
    end
    print_verdict();
  end
endmodule
